// file: src/tba_pkg.sv
`default_nettype none
package tba_pkg;
   // Capture modes selected by the core
   typedef enum logic [1:0] {
      TBA_MODE_MTC  = 2'h0,
      TBA_MODE_MSPC = 2'h1,
      TBA_MODE_ASPC = 2'h2,
      TBA_MODE_RTS  = 2'h3
   } tba_mode_e;

   // Command codes seen on the global command register
   localparam logic [15:0] TBA_CMD_CAPTURE = 16'h0800;
   localparam logic [15:0] TBA_CMD_ESCAPE  = 16'h00E8;
   // Trigger enable bit position in miscellaneous control
   localparam int          TBA_MISC_TRIG_BIT = 12;
   localparam logic [15:0] TBA_MISC_RESET    = 16'h0000;

   // Command write from the serial port decoder
   typedef struct packed {
      logic        wr;
      logic [15:0] data;
   } tba_cmd_s;

   // Status reported back by the processing core
   typedef struct packed {
      logic capture_done;
      logic record_done;
      logic buffer_loading;
      logic buffer_ready;
      logic reload_done;
   } tba_core_s;
endpackage
`default_nettype wire

// file: src/tba_sync.sv
`default_nettype none
// Two flip-flop synchroniser for an asynchronous level
module tba_sync (
   input  wire logic i_clk_sys,
   input  wire logic i_resetn,
   input  wire logic i_async,
   output logic      o_sync
);
   logic meta;
   // First stage is read only by the second
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         meta   <= 1'b0;
         o_sync <= 1'b0;
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule
`default_nettype wire

// file: src/tba_pins.sv
// Notes on behaviour
// - Trigger ignored until misc enable bit set
// - Trigger acts on edges in manual modes, on levels in streaming
// - Manual modes: rising edge starts one capture
// - Streaming modes: convert while trigger high
// - Trigger low: finish record, then halt
// - Streaming: busy low while loading buffers
// - Host avoids serial access while busy
// - Completion releases port, busy goes high
// - Escape code aborts capture even while busy
// - Alarms per control; silent in streaming
// - Supply monitor low on thermal shutdown
// - Reset pin returns device to known state
// - Reload configuration after reset release
// - Data out driven only while select low
`default_nettype none
module tba_pins (
   input  wire logic               i_clk_sys,
   input  wire logic               i_resetn,
   input  wire logic               i_trigger,
   input  wire logic               i_cs_n,
   input  wire logic               i_sdo_data,
   input  wire logic [15:0]        i_misc_ctrl,
   input  wire tba_pkg::tba_mode_e i_mode,
   input  wire tba_pkg::tba_cmd_s  i_cmd,
   input  wire tba_pkg::tba_core_s i_core,
   input  wire logic [1:0]         i_alarm_ctrl,
   input  wire logic [1:0]         i_alarm_hit,
   input  wire logic               i_over_temp,
   output logic                    o_busy,
   output logic                    o_capture_start,
   output logic                    o_capture_abort,
   output logic                    o_convert_run,
   output logic                    o_reload_req,
   output logic                    o_port_allow,
   output logic                    o_alarm_out_one,
   output logic                    o_alarm_out_two,
   output logic                    o_supply_monitor_out,
   output logic                    o_sdo,
   output logic                    o_sdo_oe
);
   import tba_pkg::*;

   ////////////////////////////////////////////////////////////////////
   logic trig_s;
   logic trig_q;
   logic trig_en;
   logic trig_rise;
   logic streaming;
   logic manual;
   logic cmd_cap;
   logic cmd_esc;
   logic start_ok;
   logic halt_pend;
   logic next_busy;
   logic [1:0] alm_raw;
   logic [1:0] alm_drive;

   // Pin passes two flops before any logic sees it
   tba_sync u_trig_sync (
      .i_clk_sys (i_clk_sys),
      .i_resetn  (i_resetn),
      .i_async   (i_trigger),
      .o_sync    (trig_s)
   );

   // Edge detect on the synchronised copy
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) trig_q <= 1'b0;
      else           trig_q <= trig_s;
   end

   assign trig_en   = i_misc_ctrl[TBA_MISC_TRIG_BIT];
   assign trig_rise = trig_en & trig_s & ~trig_q;
   assign streaming = (i_mode == TBA_MODE_RTS);
   assign manual    = (i_mode == TBA_MODE_MTC) || (i_mode == TBA_MODE_MSPC);
   assign cmd_cap   = i_cmd.wr && (i_cmd.data == TBA_CMD_CAPTURE);
   assign cmd_esc   = i_cmd.wr && (i_cmd.data == TBA_CMD_ESCAPE);
   // Starts ignored during reload or while a capture runs
   assign start_ok  = manual && !o_reload_req && o_busy && (cmd_cap || trig_rise);

   ////////////////////////////////////////////////////////////////////
   // Configuration reload after reset release
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn)              o_reload_req <= 1'b1;
      else if (i_core.reload_done) o_reload_req <= 1'b0;
   end

   // Single-cycle capture start and abort pulses
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_capture_start <= 1'b0;
         o_capture_abort <= 1'b0;
      end else begin
         o_capture_start <= start_ok;
         o_capture_abort <= cmd_esc && !o_busy && !streaming;
      end
   end

   // Next busy / data ready level; abort and completion both release the port
   always_comb begin
      next_busy = o_busy;
      if (o_reload_req) begin
         next_busy = i_core.reload_done;
      end else if (streaming) begin
         if (i_core.buffer_loading)    next_busy = 1'b0;
         else if (i_core.buffer_ready) next_busy = 1'b1;
      end else if (start_ok) begin
         next_busy = 1'b0;
      end else if (cmd_esc || i_core.capture_done) begin
         next_busy = 1'b1;
      end
   end

   // Busy register
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) o_busy <= 1'b0;
      else           o_busy <= next_busy;
   end

   // Port permission from the same next value, so it never lags busy by a cycle
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) o_port_allow <= 1'b0;
      else           o_port_allow <= next_busy || (streaming && !o_reload_req);
   end

   ////////////////////////////////////////////////////////////////////
   // Level-controlled conversion; a low level only ends at a record edge
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_convert_run <= 1'b0;
         halt_pend     <= 1'b0;
      end else if (!(streaming || i_mode == TBA_MODE_ASPC) || !trig_en || o_reload_req) begin
         o_convert_run <= 1'b0;
         halt_pend     <= 1'b0;
      end else if (trig_s) begin
         o_convert_run <= 1'b1;
         halt_pend     <= 1'b0;
      end else if (o_convert_run) begin
         // Record boundary, not the pin, ends a run
         if (i_core.record_done) begin
            o_convert_run <= 1'b0;
            halt_pend     <= 1'b0;
         end else begin
            halt_pend     <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Alarm outputs, polarity per control bit, quiet when streaming
   assign alm_raw = i_alarm_hit ^ i_alarm_ctrl;
   assign alm_drive = streaming ? 2'h0 : alm_raw;
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_alarm_out_one <= 1'b0;
         o_alarm_out_two <= 1'b0;
      end else begin
         o_alarm_out_one <= alm_drive[0];
         o_alarm_out_two <= alm_drive[1];
      end
   end

   // Supply monitor: low on over-temperature shutdown
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) o_supply_monitor_out <= 1'b1;
      else           o_supply_monitor_out <= !i_over_temp;
   end

   // Serial data out only while select is low
   always_ff @(posedge i_clk_sys) begin
      if (!i_resetn) begin
         o_sdo    <= 1'b0;
         o_sdo_oe <= 1'b0;
      end else begin
         o_sdo    <= i_sdo_data;
         o_sdo_oe <= !i_cs_n;
      end
   end

   ////////////////////////////////////////////////////////////////////
   a_start_busy: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      o_capture_start && !streaming |-> !o_busy)
      else $error("busy not low on capture start");
   a_done_busy: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      !o_reload_req && !streaming && !start_ok && i_core.capture_done |=> o_busy)
      else $error("busy not released on completion");
   a_trig_gate: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      !trig_en && !cmd_cap |=> !o_capture_start)
      else $error("start with trigger disabled");
   a_rise_start: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      manual && trig_rise && o_busy && !o_reload_req |=> o_capture_start)
      else $error("rising trigger missed");
   a_level_noretrig: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      trig_s && $past(trig_s) && !cmd_cap |-> !start_ok)
      else $error("steady level triggered");
   a_run_high: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      streaming && trig_en && trig_s && !o_reload_req |=> o_convert_run)
      else $error("conversion not running");
   a_no_trunc: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      o_convert_run && streaming && trig_en && !trig_s && !i_core.record_done
      && !o_reload_req && $stable(i_mode) |=> o_convert_run)
      else $error("record truncated");
   a_esc_abort: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      cmd_esc && !o_busy && !streaming |=> o_capture_abort ##0 o_busy)
      else $error("escape did not abort");
   a_alarm_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      streaming |=> !o_alarm_out_one && !o_alarm_out_two)
      else $error("alarm driven in streaming");
   a_sdo_hiz: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_cs_n |=> !o_sdo_oe)
      else $error("data out driven while deselected");
   a_temp_mon: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      i_over_temp |=> !o_supply_monitor_out)
      else $error("monitor not low on shutdown");
   // Mode held steady so the streaming-time permission has already been replaced
   a_port_busy: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
      !streaming && $stable(i_mode) |-> o_port_allow == o_busy)
      else $error("port permission differs from busy");
endmodule
`default_nettype wire

// file: verif/tba_host_model.sv
`default_nettype none
// Host side: owns the trigger pin, chip select and the data bit
module tba_host_model (
   input  wire logic i_clk_sys,
   input  wire logic i_busy,
   input  wire logic i_want_trig,
   input  wire logic i_want_cs,
   output logic      o_trigger,
   output logic      o_cs_n,
   output logic      o_sdo_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_trigger = 1'b0;
      o_cs_n = 1'b1;
      o_sdo_data = 1'b0;
   end
   // Pins move on the falling edge, clear of the device's sampling edge
   always @(negedge i_clk_sys) begin
      o_trigger <= i_want_trig;
      // Port opened only while the device reports ready, never mid-capture
      o_cs_n <= !(i_want_cs && i_busy);
      o_sdo_data <= !o_sdo_data; // Toggles so a stale bit never looks fresh
   end
endmodule
`default_nettype wire

// file: verif/tb_trigger_busy_alarm_pins.sv
`default_nettype none
module tb_trigger_busy_alarm_pins;
   import tba_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rstn = 1'b0, want_trig = 1'b0, want_cs = 1'b0, ot = 1'b0;
   logic        trig, cs_n, sdo_d, busy, start, abort, run, rel, pa, al1, al2, mon, oe, sdo;
   logic [15:0] misc = 16'h0000;
   logic [1:0]  actl = 2'h0, hit = 2'h0;
   logic [7:0]  lf = 8'h26;
   tba_mode_e   mode = TBA_MODE_MTC;
   tba_cmd_s    cmd = '0;
   tba_core_s   core = '0;
   int          failures = 0, total_checks = 0, starts = 0, s;
   always #4 clk = ~clk;
   tba_host_model host_u (.i_clk_sys(clk), .i_busy(busy), .i_want_trig(want_trig), .i_want_cs(want_cs),
      .o_trigger(trig), .o_cs_n(cs_n), .o_sdo_data(sdo_d));
   tba_pins dut_u (.i_clk_sys(clk), .i_resetn(rstn), .i_trigger(trig), .i_cs_n(cs_n), .i_sdo_data(sdo_d),
      .i_misc_ctrl(misc), .i_mode(mode), .i_cmd(cmd), .i_core(core), .i_alarm_ctrl(actl), .i_alarm_hit(hit),
      .i_over_temp(ot), .o_busy(busy), .o_capture_start(start), .o_capture_abort(abort), .o_convert_run(run),
      .o_reload_req(rel), .o_port_allow(pa), .o_alarm_out_one(al1), .o_alarm_out_two(al2),
      .o_supply_monitor_out(mon), .o_sdo(sdo), .o_sdo_oe(oe));
   // Start pulses counted, since the trigger path latency is only bounded
   always @(posedge clk) if (start === 1'b1) starts++;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] nx(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   function automatic logic exp_al(input logic h, input logic c, input tba_mode_e m);
      return (m == TBA_MODE_RTS) ? 1'b0 : h ^ c;
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic send(input logic [15:0] d);
      cmd = '{wr: 1'b1, data: d};
      cyc(1);
      cmd = '0;
   endtask
   task automatic pulse(input logic [4:0] c);
      core = c;
      cyc(1);
      core = '0;
   endtask
   task automatic print_verdict;
      if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Whole run is about a hundred cycles; this is ample margin
   initial begin
      #40000;
      failures++;
      print_verdict;
   end
   initial begin
      cyc(2);
      chk(busy, 0);
      chk(mon, 1);
      rstn = 1'b1;
      send(TBA_CMD_CAPTURE);
      chk(start, 0);
      chk(rel, 1);
      pulse(5'h01);
      chk({busy, rel}, 2'h2);
      send(TBA_CMD_CAPTURE);
      chk({start, busy, pa}, 3'h4);
      send(TBA_CMD_CAPTURE);
      chk({start, busy}, 2'h0);
      pulse(5'h10);
      chk({busy, pa}, 2'h3);
      send(TBA_CMD_CAPTURE);
      cyc(1); // Strobe stays low for an edge between commands
      send(TBA_CMD_ESCAPE);
      chk(abort, 1);
      cyc(1);
      chk(busy, 1);
      send(TBA_CMD_ESCAPE);
      chk(abort, 0);
      s = starts;
      want_trig <= 1'b1;
      cyc(6);
      chk(16'(starts), 16'(s));
      want_trig <= 1'b0;
      misc = 16'h1000;
      mode = TBA_MODE_MSPC;
      cyc(4);
      want_trig <= 1'b1;
      cyc(8);
      chk(16'(starts), 16'(s + 1));
      pulse(5'h10);
      for (int i = 2; i < 4; i++) begin
         mode = tba_mode_e'(i);
         want_trig <= 1'b1;
         cyc(6);
         chk(run, 1);
         want_trig <= 1'b0;
         cyc(6);
         chk(run, 1);
         pulse(5'h08);
         chk(run, 0);
      end
      send(TBA_CMD_CAPTURE);
      chk(start, 0);
      pulse(5'h04);
      chk(busy, 0);
      cyc(1);
      pulse(5'h02);
      chk(busy, 1);
      // Random alarm, thermal and select traffic across all modes
      for (int i = 0; i < 40; i++) begin
         lf = nx(lf);
         {hit, actl, ot} = lf[4:0];
         want_cs <= lf[5];
         mode = tba_mode_e'(lf[7:6]);
         cyc(1);
         chk(al1, exp_al(hit[0], actl[0], mode));
         chk(al2, exp_al(hit[1], actl[1], mode));
         chk(mon, !ot);
         chk(oe, !cs_n);
         chk(sdo, sdo_d);
      end
      rstn = 1'b0;
      cyc(1);
      chk({busy, rel, run}, 3'h2);
      // Second release: reload must finish again before the port opens
      rstn = 1'b1;
      pulse(5'h01);
      chk({busy, rel}, 2'h2);
      print_verdict;
   end
endmodule
`default_nettype wire
